/* dv/bfpf_port_model.sv */
`default_nettype none

// Processor on one port: free-running clock, one operation per call
module bfpf_port_model
  import bfpf_pkg::*;
#(
  parameter int HALF = 3
)
(
  // Clock
  input  wire logic      ref_clk,
  // Port pins
  output logic           port_clk,
  output logic           select_n,
  output logic           dir,
  output logic           go,
  output logic           mail_sel,
  output logic [QDW-1:0] drv
);
  timeunit 1ns;
  timeprecision 1ns;

  int cnt = 0;

  // Pins at time zero: selected, no operation
  initial
  begin
    port_clk = 1'b0;
    select_n = 1'b0;
    dir = 1'b0;
    go = 1'b0;
    mail_sel = 1'b0;
    drv = '0;
  end

  // Port clock runs free, also between operations
  always @(posedge ref_clk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      port_clk <= ~port_clk;
  end

  // Controls change at a falling edge and hold a whole port cycle,
  // so the device sees them stable around the rising edge
  task automatic op(input logic s, input logic d, input logic g,
                    input logic m, input logic [QDW-1:0] v);
    @(negedge port_clk);
    select_n <= s;
    dir      <= d;
    go       <= g;
    mail_sel <= m;
    drv      <= v;
    @(negedge port_clk);
    go  <= 1'b0;
    drv <= ~v;      // Caller never trusts a refused write
    repeat (2) @(posedge ref_clk);
  endtask
endmodule // bfpf_port_model

`default_nettype wire

/* dv/bfpf_tb_top.sv */
`default_nettype none

module bfpf_tb_top
  import bfpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****
  // Bench
  // ****
  logic           ref_clk = 1'b0;
  logic           rst = 1'b1;
  logic           clr_ab = 1'b1;
  logic           clr_ba = 1'b1;
  logic [QPW-1:0] x_ab = 9'h002;
  logic [QPW-1:0] y_ab = 9'h008;
  logic [QPW-1:0] x_ba = 9'h004;
  logic [QPW-1:0] y_ba = 9'h008;
  logic           a_clk, a_sel_n, a_dir, a_go, a_ms;
  logic           b_clk, b_sel_n, b_dir, b_go, b_ms;
  logic [QDW-1:0] a_drv, b_drv, a_din, b_din, a_dout, b_dout;
  logic           a_oe, a_sp, a_hf_n, a_wv, a_lf_n, m_ba_n;
  logic           b_oe, b_sp, b_hf_n, b_wv, b_lf_n, m_ab_n;
  int             n_errors = 0;
  int             tests_run = 0;
  int             i;

  // Data lines: the device wins while it drives
  assign a_din = a_oe ? a_dout : a_drv;
  assign b_din = b_oe ? b_dout : b_drv;

  always #50 ref_clk = ~ref_clk;

  // Unequal port clocks keep the crossings unaligned
  bfpf_port_model #(.HALF(3)) u_a (.ref_clk(ref_clk), .port_clk(a_clk),
    .select_n(a_sel_n), .dir(a_dir), .go(a_go), .mail_sel(a_ms),
    .drv(a_drv));
  bfpf_port_model #(.HALF(4)) u_b (.ref_clk(ref_clk), .port_clk(b_clk),
    .select_n(b_sel_n), .dir(b_dir), .go(b_go), .mail_sel(b_ms),
    .drv(b_drv));

  bfpf_top DUT (.ref_clk(ref_clk), .rst(rst),
    .queue_ab_clear(clr_ab), .queue_ba_clear(clr_ba),
    .empty_offset_ab(x_ab), .full_offset_ab(y_ab),
    .empty_offset_ba(x_ba), .full_offset_ba(y_ba),
    .a_side_clock(a_clk), .a_side_select_n(a_sel_n),
    .a_side_dir_write(a_dir), .a_side_go(a_go), .a_side_mail_sel(a_ms),
    .a_data_in(a_din), .a_data_out(a_dout), .a_data_oe(a_oe),
    .a_side_space_flag(a_sp), .a_side_high_fill_n(a_hf_n),
    .a_side_word_valid(a_wv), .a_side_low_fill_n(a_lf_n),
    .mail_ba_pending_n(m_ba_n),
    .b_side_clock(b_clk), .b_side_select_n(b_sel_n),
    .b_side_dir_read(b_dir), .b_side_go(b_go), .b_side_mail_sel(b_ms),
    .b_data_in(b_din), .b_data_out(b_dout), .b_data_oe(b_oe),
    .b_side_space_flag(b_sp), .b_side_high_fill_n(b_hf_n),
    .b_side_word_valid(b_wv), .b_side_low_fill_n(b_lf_n),
    .mail_ab_pending_n(m_ab_n));

  function automatic logic [QDW-1:0] w(input int k);
    return 36'h0a5000000 + k;
  endfunction

  task automatic check(input logic [QDW-1:0] got, input logic [QDW-1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Longer than three slow port cycles plus the pin synchronisers
  task automatic settle();
    repeat (48) @(posedge ref_clk);
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic s_decode();
    check({a_sp, a_hf_n, a_wv, a_lf_n, m_ba_n}, 5'b11001);
    check({b_sp, b_hf_n, b_wv, b_lf_n, m_ab_n}, 5'b11001);
    u_a.op(1'b1, 1'b1, 1'b1, 1'b0, 36'h1);
    u_a.op(1'b0, 1'b1, 1'b0, 1'b0, 36'h2);
    settle();
    check({b_wv, a_oe}, 2'b00);
    u_a.op(1'b0, 1'b0, 1'b0, 1'b0, 36'h0);
    check(a_oe, 1'b1);
    u_b.op(1'b1, 1'b1, 1'b0, 1'b0, 36'h0);
    check(b_oe, 1'b0);
    u_b.op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
    check(b_oe, 1'b1);
  endtask

  // First word falls through, then the low-fill threshold and reads
  task automatic s_fall();
    u_a.op(1'b0, 1'b1, 1'b1, 1'b0, w(0));
    check(b_wv, 1'b0);
    settle();
    check({b_wv, b_lf_n}, 2'b10);
    check(b_dout, w(0));
    for (i = 1; i < 4; i++)
    begin
      u_a.op(1'b0, 1'b1, 1'b1, 1'b0, w(i));
      settle();
      check(b_lf_n, i == 3);
    end
    for (i = 0; i < 4; i++)
    begin
      check(b_dout, w(i));
      u_b.op(1'b0, 1'b1, 1'b1, 1'b0, 36'h0);
      settle();
    end
    check(b_wv, 1'b0);
    u_b.op(1'b0, 1'b1, 1'b1, 1'b0, 36'h0);
    check(b_dout, w(3));
  endtask

  task automatic s_mail();
    u_a.op(1'b0, 1'b1, 1'b1, 1'b1, 36'h111111111);
    check(m_ab_n, 1'b0);
    u_a.op(1'b0, 1'b1, 1'b1, 1'b1, 36'h222222222);
    u_b.op(1'b0, 1'b1, 1'b1, 1'b1, 36'h0);
    check({m_ab_n, b_dout}, {1'b1, 36'h111111111});
    u_b.op(1'b0, 1'b0, 1'b1, 1'b1, 36'h333333333);
    check(m_ba_n, 1'b0);
    u_a.op(1'b0, 1'b0, 1'b1, 1'b1, 36'h0);
    check({m_ba_n, a_dout}, {1'b1, 36'h333333333});
  endtask

  // Fill the B-to-A queue to full, refuse one, then drain it
  task automatic s_full();
    for (i = 0; i < 249; i++)
    begin
      if (i == 248)
      begin
        settle();
        check(b_hf_n, 1'b1);
      end
      u_b.op(1'b0, 1'b0, 1'b1, 1'b0, w(100 + i));
    end
    settle();
    check(b_hf_n, 1'b0);
    for (i = 249; i < 257; i++)
      u_b.op(1'b0, 1'b0, 1'b1, 1'b0, w(100 + i));
    settle();
    check({b_sp, a_wv, a_lf_n}, 3'b011);
    u_b.op(1'b0, 1'b0, 1'b1, 1'b0, 36'h0dead0000);
    u_a.op(1'b0, 1'b0, 1'b0, 1'b0, 36'h0);
    for (i = 0; i < 257; i++)
    begin
      check(a_dout, w(100 + i));
      u_a.op(1'b0, 1'b0, 1'b1, 1'b0, 36'h0);
      if (i == 0)
      begin
        check(b_sp, 1'b0);
        settle();
        check(b_sp, 1'b1);
      end
    end
    check(a_wv, 1'b0);
  endtask

  // Clear the A-to-B queue alone with a new empty offset;
  // the word parked in the B-to-A queue must survive
  task automatic s_clear();
    u_b.op(1'b0, 1'b0, 1'b1, 1'b0, w(600));
    x_ab   <= 9'h001;
    clr_ab <= 1'b1;
    repeat (4) @(posedge ref_clk);
    clr_ab <= 1'b0;
    settle();
    check({b_wv, b_lf_n, a_wv, m_ab_n}, 4'b0011);
    for (i = 0; i < 3; i++)
      u_a.op(1'b0, 1'b1, 1'b1, 1'b0, w(500 + i));
    settle();
    check({b_wv, b_lf_n}, 2'b11);
    check(b_dout, w(500));
  endtask

  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    clr_ab <= 1'b0;
    clr_ba <= 1'b0;
    repeat (4) @(posedge ref_clk);
    s_decode();
    s_fall();
    s_mail();
    s_full();
    s_clear();
    print_verdict();
  end

  // Watchdog: the tests take about 8300 cycles
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end
endmodule // bfpf_tb_top

`default_nettype wire

/* pkg/bfpf_pkg.sv */
`default_nettype none

package bfpf_pkg;

  // ****************************************************
  // Sizes
  // ****************************************************
  localparam int QDEPTH = 256;
  localparam int QAW    = $clog2(QDEPTH);
  localparam int QPW    = QAW + 1;
  localparam int QDW    = 36;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic RST_SPACE       = 1'b1;
  localparam logic RST_HIGH_FILL_N = 1'b1;
  localparam logic RST_WORD_VALID  = 1'b0;
  localparam logic RST_LOW_FILL_N  = 1'b0;
  localparam logic RST_PENDING_N   = 1'b1;

  // ****************************************************
  // Carriers
  // ****************************************************
  // Port pins after sampling; dir is write for A, read for B
  typedef struct packed {
    logic select_n;
    logic dir;
    logic go;
    logic mail_sel;
  } bfpf_ctrl_t;

  // Idle controls: deselected, so no output enable right after reset
  localparam bfpf_ctrl_t RST_CTRL = 4'h8;

  // Decoded port operation, one-cycle pulses
  typedef struct packed {
    logic wr_q;
    logic wr_m;
    logic rd_q;
    logic rd_m;
  } bfpf_op_t;

endpackage

`default_nettype wire

/* src/bfpf_queue.sv */
`default_nettype none

module bfpf_queue
  import bfpf_pkg::*;
#(
  parameter  int DEPTH = QDEPTH,
  localparam int AW    = $clog2(DEPTH),
  localparam int PW    = AW + 1
)
(
  // Clock and resets
  input  wire logic           ref_clk,
  input  wire logic           rst,
  input  wire logic           clear,
  // Offsets, taken while clear is high
  input  wire logic [PW-1:0]  empty_offset,
  input  wire logic [PW-1:0]  full_offset,
  // Writing side
  input  wire logic           wr_tick,
  input  wire logic           wr_en,
  input  wire logic [QDW-1:0] wr_data,
  output logic                space,
  output logic                high_fill_n,
  // Reading side
  input  wire logic           rd_tick,
  input  wire logic           rd_en,
  output logic [QDW-1:0]      rd_data,
  output logic                word_valid,
  output logic                low_fill_n
);

  localparam logic [PW-1:0] DEPTH_V = PW'(DEPTH);
  localparam logic [PW-1:0] ONE     = PW'(1);

  logic [QDW-1:0] mem [DEPTH];
  logic [PW-1:0]  wptr, rptr, x_ofs, y_ofs;
  logic [PW-1:0]  wptr_s1, wptr_s2, rptr_s1, rptr_s2;
  logic [PW-1:0]  next_wptr, next_rptr, wr_count, rd_count;
  logic           wr_ok, load;

  // ****************************************************
  // Pointer arithmetic
  // ****************************************************
  assign wr_ok     = wr_tick && wr_en && space;
  assign next_wptr = wr_ok ? wptr + ONE : wptr;
  // Older far pointer only overstates fill, never loses a word
  assign wr_count  = next_wptr - rptr_s1;
  // Fall-through needs no read; a read empties the register
  assign load      = rd_tick && (wptr_s2 != rptr)
                     && (!word_valid || rd_en);
  assign next_rptr = load ? rptr + ONE : rptr;
  assign rd_count  = wptr_s1 - next_rptr;

  // Offsets held per queue
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      x_ofs <= '0;
      y_ofs <= '0;
    end
    else if (clear)
    begin
      x_ofs <= empty_offset;
      y_ofs <= full_offset;
    end

  // Storage has no reset
  always_ff @(posedge ref_clk)
    if (wr_ok)
      mem[wptr[AW-1:0]] <= wr_data;

  // Writer side pointer and flags; queue clear kept off the async path
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      wptr        <= '0;
      rptr_s1     <= '0;
      rptr_s2     <= '0;
      space       <= RST_SPACE;
      high_fill_n <= RST_HIGH_FILL_N;
    end
    else if (clear)
    begin
      wptr        <= '0;
      rptr_s1     <= '0;
      rptr_s2     <= '0;
      space       <= RST_SPACE;
      high_fill_n <= RST_HIGH_FILL_N;
    end
    else if (wr_tick)
    begin
      wptr        <= next_wptr;
      rptr_s1     <= rptr;
      rptr_s2     <= rptr_s1;
      space       <= wr_count != DEPTH_V;
      high_fill_n <= wr_count < (DEPTH_V - y_ofs);
    end

  // Reader side pointer, output register and flags
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      rptr       <= '0;
      wptr_s1    <= '0;
      wptr_s2    <= '0;
      rd_data    <= '0;
      word_valid <= RST_WORD_VALID;
      low_fill_n <= RST_LOW_FILL_N;
    end
    else if (clear)
    begin
      rptr       <= '0;
      wptr_s1    <= '0;
      wptr_s2    <= '0;
      rd_data    <= '0;
      word_valid <= RST_WORD_VALID;
      low_fill_n <= RST_LOW_FILL_N;
    end
    else if (rd_tick)
    begin
      rptr       <= next_rptr;
      wptr_s1    <= wptr;
      wptr_s2    <= wptr_s1;
      low_fill_n <= rd_count > x_ofs;
      if (load)
      begin
        rd_data    <= mem[rptr[AW-1:0]];
        word_valid <= 1'b1;
      end
      else if (rd_en)
        word_valid <= 1'b0;
    end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_arrive;
    rd_tick && !clear && (wptr_s2 != rptr) && !word_valid;
  endsequence

  property p_drop_full;
    wr_tick && wr_en && !space && !clear |=> wptr == $past(wptr);
  endproperty
  a_drop_full: assert property (p_drop_full)
    else $error("write stored while space flag low");

  property p_wptr_step;
    wr_tick && wr_en && space && !clear |=> wptr == $past(wptr) + ONE;
  endproperty
  a_wptr_step: assert property (p_wptr_step)
    else $error("write pointer did not advance by one");

  property p_no_overflow;
    (wptr - rptr) <= DEPTH_V;
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("memory count exceeds depth");

  property p_space_level;
    space == ((wptr - rptr_s2) != DEPTH_V);
  endproperty
  a_space_level: assert property (p_space_level)
    else $error("space flag disagrees with synchronized fill");

  property p_high_fill;
    high_fill_n == ((wptr - rptr_s2) < (DEPTH_V - y_ofs));
  endproperty
  a_high_fill: assert property (p_high_fill)
    else $error("high-fill flag disagrees with fill");

  property p_low_fill;
    low_fill_n == ((wptr_s2 - rptr) > x_ofs);
  endproperty
  a_low_fill: assert property (p_low_fill)
    else $error("low-fill flag disagrees with fill");

  property p_fall_through;
    s_arrive |=> word_valid && (rptr == $past(rptr) + ONE);
  endproperty
  a_fall_through: assert property (p_fall_through)
    else $error("first word did not fall through");

  property p_hold_idle;
    rd_tick && !clear && !word_valid && (wptr_s2 == rptr)
      |=> $stable(rd_data) && !word_valid;
  endproperty
  a_hold_idle: assert property (p_hold_idle)
    else $error("output register changed while empty");

endmodule // bfpf_queue

`default_nettype wire

/* src/bfpf_top.sv */
`default_nettype none

module bfpf_top
  import bfpf_pkg::*;
(
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst,
  // Queue resets and offsets
  input  wire logic           queue_ab_clear,
  input  wire logic           queue_ba_clear,
  input  wire logic [QPW-1:0] empty_offset_ab,
  input  wire logic [QPW-1:0] full_offset_ab,
  input  wire logic [QPW-1:0] empty_offset_ba,
  input  wire logic [QPW-1:0] full_offset_ba,
  // Port A pins
  input  wire logic           a_side_clock,
  input  wire logic           a_side_select_n,
  input  wire logic           a_side_dir_write,
  input  wire logic           a_side_go,
  input  wire logic           a_side_mail_sel,
  input  wire logic [QDW-1:0] a_data_in,
  output logic [QDW-1:0]      a_data_out,
  output logic                a_data_oe,
  // Port A flags
  output wire logic           a_side_space_flag,
  output wire logic           a_side_high_fill_n,
  output wire logic           a_side_word_valid,
  output wire logic           a_side_low_fill_n,
  output logic                mail_ba_pending_n,
  // Port B pins
  input  wire logic           b_side_clock,
  input  wire logic           b_side_select_n,
  input  wire logic           b_side_dir_read,
  input  wire logic           b_side_go,
  input  wire logic           b_side_mail_sel,
  input  wire logic [QDW-1:0] b_data_in,
  output logic [QDW-1:0]      b_data_out,
  output logic                b_data_oe,
  // Port B flags
  output wire logic           b_side_space_flag,
  output wire logic           b_side_high_fill_n,
  output wire logic           b_side_word_valid,
  output wire logic           b_side_low_fill_n,
  output logic                mail_ab_pending_n
);

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [1:0]     clk_s1;
  logic [1:0]     clk_s2;
  logic [1:0]     clk_s3;
  logic [1:0]     tick;
  bfpf_ctrl_t     a_ctl_s1;
  bfpf_ctrl_t     a_ctl;
  bfpf_ctrl_t     b_ctl_s1;
  bfpf_ctrl_t     b_ctl;
  logic [QDW-1:0] a_din_s1;
  logic [QDW-1:0] a_din;
  logic [QDW-1:0] b_din_s1;
  logic [QDW-1:0] b_din;
  logic [1:0]     clr_s1;
  logic [1:0]     clr;
  logic [QPW-1:0] ofs_s1 [4];
  logic [QPW-1:0] ofs [4];

  // Port clocks are only sampled; bit 0 is A, bit 1 is B
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      clk_s1 <= '0;
      clk_s2 <= '0;
      clk_s3 <= '0;
    end
    else
    begin
      clk_s1 <= {b_side_clock, a_side_clock};
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end

  // Rising port edge, one cycle; edge detect reads stage two
  assign tick = clk_s2 & ~clk_s3;

  // Controls and data take the same two stages as the clocks,
  // so the sampled values line up with the detected edge
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      a_ctl_s1 <= RST_CTRL;
      a_ctl    <= RST_CTRL;
      b_ctl_s1 <= RST_CTRL;
      b_ctl    <= RST_CTRL;
      a_din_s1 <= '0;
      a_din    <= '0;
      b_din_s1 <= '0;
      b_din    <= '0;
    end
    else
    begin
      a_ctl_s1 <= {a_side_select_n, a_side_dir_write,
                   a_side_go, a_side_mail_sel};
      a_ctl    <= a_ctl_s1;
      b_ctl_s1 <= {b_side_select_n, b_side_dir_read,
                   b_side_go, b_side_mail_sel};
      b_ctl    <= b_ctl_s1;
      a_din_s1 <= a_data_in;
      a_din    <= a_din_s1;
      b_din_s1 <= b_data_in;
      b_din    <= b_din_s1;
    end

  // Queue clears and offsets
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      clr_s1 <= '0;
      clr    <= '0;
      for (int i = 0; i < 4; i++)
      begin
        ofs_s1[i] <= '0;
        ofs[i]    <= '0;
      end
    end
    else
    begin
      clr_s1    <= {queue_ba_clear, queue_ab_clear};
      clr       <= clr_s1;
      ofs_s1[0] <= empty_offset_ab;
      ofs_s1[1] <= full_offset_ab;
      ofs_s1[2] <= empty_offset_ba;
      ofs_s1[3] <= full_offset_ba;
      for (int i = 0; i < 4; i++)
        ofs[i] <= ofs_s1[i];
    end

  // ****************************************************
  // Port decode
  // ****************************************************
  bfpf_op_t a_op;
  bfpf_op_t b_op;

  // Port A: dir high writes; go low does nothing
  always_comb
  begin
    a_op = '0;
    if (tick[0] && !a_ctl.select_n && a_ctl.go)
    begin
      a_op.wr_q = a_ctl.dir && !a_ctl.mail_sel;
      a_op.wr_m = a_ctl.dir && a_ctl.mail_sel;
      a_op.rd_q = !a_ctl.dir && !a_ctl.mail_sel;
      a_op.rd_m = !a_ctl.dir && a_ctl.mail_sel;
    end
  end

  // Port B: same table with direction sense inverted
  always_comb
  begin
    b_op = '0;
    if (tick[1] && !b_ctl.select_n && b_ctl.go)
    begin
      b_op.wr_q = !b_ctl.dir && !b_ctl.mail_sel;
      b_op.wr_m = !b_ctl.dir && b_ctl.mail_sel;
      b_op.rd_q = b_ctl.dir && !b_ctl.mail_sel;
      b_op.rd_m = b_ctl.dir && b_ctl.mail_sel;
    end
  end

  // ****************************************************
  // Queues
  // ****************************************************
  logic [QDW-1:0] ab_rd_data;
  logic [QDW-1:0] ba_rd_data;

  // A writes, B reads
  bfpf_queue #(
    .DEPTH        (QDEPTH)
  ) u_queue_a_to_b (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .clear        (clr[0]),
    .empty_offset (ofs[0]),
    .full_offset  (ofs[1]),
    .wr_tick      (tick[0]),
    .wr_en        (a_op.wr_q),
    .wr_data      (a_din),
    .space        (a_side_space_flag),
    .high_fill_n  (a_side_high_fill_n),
    .rd_tick      (tick[1]),
    .rd_en        (b_op.rd_q),
    .rd_data      (ab_rd_data),
    .word_valid   (b_side_word_valid),
    .low_fill_n   (b_side_low_fill_n)
  );

  // B writes, A reads
  bfpf_queue #(
    .DEPTH        (QDEPTH)
  ) u_queue_b_to_a (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .clear        (clr[1]),
    .empty_offset (ofs[2]),
    .full_offset  (ofs[3]),
    .wr_tick      (tick[1]),
    .wr_en        (b_op.wr_q),
    .wr_data      (b_din),
    .space        (b_side_space_flag),
    .high_fill_n  (b_side_high_fill_n),
    .rd_tick      (tick[0]),
    .rd_en        (a_op.rd_q),
    .rd_data      (ba_rd_data),
    .word_valid   (a_side_word_valid),
    .low_fill_n   (a_side_low_fill_n)
  );

  // ****************************************************
  // Mailboxes
  // ****************************************************
  logic [QDW-1:0] mailbox_a_to_b;
  logic [QDW-1:0] mailbox_b_to_a;

  // New mail is taken only into an empty box; while mail is pending, a read in the same cycle wins and the new mail is lost
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      mailbox_a_to_b    <= '0;
      mail_ab_pending_n <= RST_PENDING_N;
    end
    else if (a_op.wr_m && mail_ab_pending_n)
    begin
      mailbox_a_to_b    <= a_din;
      mail_ab_pending_n <= 1'b0;
    end
    else if (b_op.rd_m)
      mail_ab_pending_n <= 1'b1;

  // Mirror for the B-to-A box
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      mailbox_b_to_a    <= '0;
      mail_ba_pending_n <= RST_PENDING_N;
    end
    else if (b_op.wr_m && mail_ba_pending_n)
    begin
      mailbox_b_to_a    <= b_din;
      mail_ba_pending_n <= 1'b0;
    end
    else if (a_op.rd_m)
      mail_ba_pending_n <= 1'b1;

  // ****************************************************
  // Data pins
  // ****************************************************
  // Enable follows select and direction, not the port clock
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      a_data_oe  <= 1'b0;
      a_data_out <= '0;
      b_data_oe  <= 1'b0;
      b_data_out <= '0;
    end
    else
    begin
      a_data_oe  <= !a_ctl.select_n && !a_ctl.dir;
      a_data_out <= a_ctl.mail_sel ? mailbox_b_to_a
                                   : ba_rd_data;
      b_data_oe  <= !b_ctl.select_n && b_ctl.dir;
      b_data_out <= b_ctl.mail_sel ? mailbox_a_to_b
                                   : ab_rd_data;
    end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_ab_mail_in;
    a_op.wr_m && mail_ab_pending_n;
  endsequence

  sequence s_ba_mail_in;
    b_op.wr_m && mail_ba_pending_n;
  endsequence

  property p_ab_mail_write;
    s_ab_mail_in |=> !mail_ab_pending_n
                     && (mailbox_a_to_b == $past(a_din));
  endproperty
  a_ab_mail_write: assert property (p_ab_mail_write)
    else $error("mailbox A-to-B write not taken");

  property p_ab_mail_busy;
    a_op.wr_m && !mail_ab_pending_n |=> $stable(mailbox_a_to_b);
  endproperty
  a_ab_mail_busy: assert property (p_ab_mail_busy)
    else $error("mailbox A-to-B overwritten while pending");

  property p_ab_mail_read;
    b_op.rd_m && !a_op.wr_m |=> mail_ab_pending_n;
  endproperty
  a_ab_mail_read: assert property (p_ab_mail_read)
    else $error("mailbox A-to-B read left pending low");

  property p_ba_mail_write;
    s_ba_mail_in |=> !mail_ba_pending_n
                     && (mailbox_b_to_a == $past(b_din));
  endproperty
  a_ba_mail_write: assert property (p_ba_mail_write)
    else $error("mailbox B-to-A write not taken");

  property p_ba_mail_read;
    a_op.rd_m && !b_op.wr_m |=> mail_ba_pending_n;
  endproperty
  a_ba_mail_read: assert property (p_ba_mail_read)
    else $error("mailbox B-to-A read left pending low");

  property p_a_drive;
    ##1 a_data_oe == $past(!a_ctl.select_n && !a_ctl.dir);
  endproperty
  a_a_drive: assert property (p_a_drive)
    else $error("port A output enable wrong");

  property p_b_drive;
    ##1 b_data_oe == $past(!b_ctl.select_n && b_ctl.dir);
  endproperty
  a_b_drive: assert property (p_b_drive)
    else $error("port B output enable wrong");

  property p_a_mail_out;
    $past(a_ctl.mail_sel) && a_data_oe
      |-> a_data_out == $past(mailbox_b_to_a);
  endproperty
  a_a_mail_out: assert property (p_a_mail_out)
    else $error("port A mailbox data wrong");

  property p_b_valid_on_edge;
    !tick[1] && !clr[0] |=> $stable(b_side_word_valid)
                            && $stable(b_side_low_fill_n);
  endproperty
  a_b_valid_on_edge: assert property (p_b_valid_on_edge)
    else $error("port B flags moved without a port B edge");

  property p_a_space_on_edge;
    !tick[0] && !clr[0] |=> $stable(a_side_space_flag);
  endproperty
  a_a_space_on_edge: assert property (p_a_space_on_edge)
    else $error("port A space flag moved without a port A edge");

  property p_idle_port;
    !a_ctl.go |-> a_op == '0;
  endproperty
  a_idle_port: assert property (p_idle_port)
    else $error("port A acted with enable low");

endmodule // bfpf_top

`default_nettype wire
